// *** logic/irs_pkg.sv ***
// Shared constants and types of the two-wire register slave
package irs_pkg;

  // Widths of the bus address, pointer and register word
  localparam int IRS_ADDR_W = 7;
  localparam int IRS_PTR_W = 8;
  localparam int IRS_WORD_W = 16;

  // Default own bus address; value is arbitrary
  localparam logic [IRS_ADDR_W-1:0] IRS_OWN_ADDR_DEF = 7'h2A;

  // Bit counter values of the first and last data bits of a byte
  localparam logic [2:0] IRS_BIT_FIRST = 3'h0;
  localparam logic [2:0] IRS_BIT_LAST = 3'h7;

  // Reset values
  localparam logic [IRS_PTR_W-1:0] IRS_PTR_RST = 8'h00;
  localparam logic [7:0] IRS_BYTE_RST = 8'h00;
  localparam logic [IRS_WORD_W-1:0] IRS_WORD_RST = 16'h0000;

  // Direction bit and acknowledge level
  localparam logic IRS_DIR_WRITE = 1'b0;
  localparam logic IRS_DIR_READ = 1'b1;
  localparam logic IRS_ACK = 1'b0;

  // Protocol states
  typedef enum logic [4:0] {
    IRS_ST_IDLE = 5'b00001,
    IRS_ST_RX = 5'b00010,
    IRS_ST_ACK = 5'b00100,
    IRS_ST_TX = 5'b01000,
    IRS_ST_MACK = 5'b10000
  } irs_state_t;

  // Meaning of the next byte received in a write transfer
  typedef enum logic [3:0] {
    IRS_K_ADDR = 4'b0001,
    IRS_K_PTR = 4'b0010,
    IRS_K_HI = 4'b0100,
    IRS_K_LO = 4'b1000
  } irs_kind_t;

  // Register write command towards the register file
  typedef struct packed {
    logic [IRS_PTR_W-1:0] addr;
    logic [IRS_WORD_W-1:0] data;
  } irs_wr_t;

  // Register read request towards the register file
  typedef struct packed {
    logic en;
    logic [IRS_PTR_W-1:0] addr;
  } irs_rd_t;

endpackage

// *** logic/irs_slave.sv ***
// Two-wire bus slave giving access to 16-bit registers through a pointer
`timescale 1ns/1ps

module irs_slave
#(
  parameter logic [irs_pkg::IRS_ADDR_W-1:0] OWN_ADDR = irs_pkg::IRS_OWN_ADDR_DEF
)
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial link
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Register file side
  output irs_pkg::irs_wr_t reg_wr,
  output logic reg_wr_valid,
  output irs_pkg::irs_rd_t reg_rd,
  input wire logic [irs_pkg::IRS_WORD_W-1:0] reg_rd_data,
  // Status
  output logic busy,
  output logic selected
);
  import irs_pkg::*;

  // Picks one byte of a register word
  function automatic logic [7:0] word_byte(input logic [IRS_WORD_W-1:0] w, input logic hi);
    word_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // Link domain: data bit captured on each rising SCL, with event toggle
  logic bit_val_q;
  logic bit_tgl_q;

  always_ff @(posedge scl_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_val_q <= 1'b0;
      bit_tgl_q <= 1'b0;
    end
    else
    begin
      bit_val_q <= sda_in;
      bit_tgl_q <= ~bit_tgl_q;
    end
  end

  // System domain synchronisers for the pins and the bit event
  logic scl_meta_q;
  logic scl_s_q;
  logic scl_d1_q;
  logic sda_meta_q;
  logic sda_s_q;
  logic sda_d1_q;
  logic tgl_meta_q;
  logic tgl_s_q;
  logic tgl_d1_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_meta_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d1_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d1_q <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_d1_q <= 1'b0;
    end
    else
    begin
      scl_meta_q <= scl_clk;
      scl_s_q <= scl_meta_q;
      scl_d1_q <= scl_s_q;
      sda_meta_q <= sda_in;
      sda_s_q <= sda_meta_q;
      sda_d1_q <= sda_s_q;
      tgl_meta_q <= bit_tgl_q;
      tgl_s_q <= tgl_meta_q;
      tgl_d1_q <= tgl_s_q;
    end
  end

  // Bus events seen in the system domain
  logic start_ev;
  logic stop_ev;
  logic scl_fall;
  logic bit_ev;

  assign start_ev = scl_s_q && scl_d1_q && sda_d1_q && !sda_s_q;
  assign stop_ev = scl_s_q && scl_d1_q && !sda_d1_q && sda_s_q;
  assign scl_fall = scl_d1_q && !scl_s_q;
  // Bit value is stable for a whole SCL period after its toggle
  assign bit_ev = tgl_s_q ^ tgl_d1_q;

  // Protocol state
  irs_state_t st_q;
  irs_kind_t kind_q;
  logic [2:0] cnt_q;
  logic [6:0] rx_sr_q;
  logic rw_q;
  logic [IRS_PTR_W-1:0] ptr_q;
  logic [7:0] hi_q;
  logic [IRS_WORD_W-1:0] word_q;
  logic [7:0] tx_sr_q;
  logic tx_lo_q;
  logic drv_low_q;

  logic [7:0] rx_byte;
  logic rx_done;
  logic adr_ok;
  logic tx_fetch;
  logic tx_next_lo;
  logic tx_done;

  assign rx_byte = {rx_sr_q, bit_val_q};
  assign rx_done = bit_ev && (st_q == IRS_ST_RX) && (cnt_q == IRS_BIT_LAST);
  assign adr_ok = rx_done && (kind_q == IRS_K_ADDR) && (rx_byte[7:1] == OWN_ADDR);
  // new word fetched after address or after acknowledged low byte
  assign tx_fetch = bit_ev && !start_ev && !stop_ev && (((st_q == IRS_ST_ACK)
                    && (rw_q == IRS_DIR_READ)) || ((st_q == IRS_ST_MACK)
                    && (bit_val_q == IRS_ACK) && tx_lo_q));
  assign tx_next_lo = bit_ev && (st_q == IRS_ST_MACK) && (bit_val_q == IRS_ACK)
                      && !tx_lo_q;
  assign tx_done = bit_ev && (st_q == IRS_ST_TX) && (cnt_q == IRS_BIT_LAST);

  // Main protocol sequence
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= IRS_ST_IDLE;
    end
    else if (start_ev)
    begin
      st_q <= IRS_ST_RX;
    end
    else if (stop_ev)
    begin
      st_q <= IRS_ST_IDLE;
    end
    else if (bit_ev)
    begin
      case (st_q)
        IRS_ST_RX:
        begin
          if (cnt_q == IRS_BIT_LAST)
          begin
            // mismatch stays idle until next start
            if (kind_q == IRS_K_ADDR && !adr_ok)
            begin
              st_q <= IRS_ST_IDLE;
            end
            else
            begin
              st_q <= IRS_ST_ACK;
            end
          end
        end
        IRS_ST_ACK:
        begin
          st_q <= (rw_q == IRS_DIR_READ) ? IRS_ST_TX : IRS_ST_RX;
        end
        IRS_ST_TX:
        begin
          if (cnt_q == IRS_BIT_LAST)
          begin
            st_q <= IRS_ST_MACK;
          end
        end
        IRS_ST_MACK:
        begin
          st_q <= (bit_val_q == IRS_ACK) ? IRS_ST_TX : IRS_ST_IDLE;
        end
        default:
        begin
          st_q <= IRS_ST_IDLE;
        end
      endcase
    end
  end

  // Bit counter and receive shifter
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= IRS_BIT_FIRST;
      rx_sr_q <= 7'h00;
    end
    else if (start_ev || stop_ev)
    begin
      cnt_q <= IRS_BIT_FIRST;
    end
    else if (bit_ev)
    begin
      if (st_q == IRS_ST_RX || st_q == IRS_ST_TX)
      begin
        cnt_q <= cnt_q + 3'h1;
      end
      else
      begin
        cnt_q <= IRS_BIT_FIRST;
      end
      rx_sr_q <= rx_byte[6:0];
    end
  end

  // Byte meaning, direction and pointer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      kind_q <= IRS_K_ADDR;
      rw_q <= IRS_DIR_WRITE;
      ptr_q <= IRS_PTR_RST;
      hi_q <= IRS_BYTE_RST;
    end
    else if (start_ev)
    begin
      kind_q <= IRS_K_ADDR;
      rw_q <= IRS_DIR_WRITE;
    end
    else if (rx_done && !stop_ev)
    begin
      case (kind_q)
        IRS_K_ADDR:
        begin
          rw_q <= rx_byte[0];
          kind_q <= IRS_K_PTR;
        end
        IRS_K_PTR:
        begin
          // first write byte loads the pointer
          ptr_q <= rx_byte;
          kind_q <= IRS_K_HI;
        end
        IRS_K_HI:
        begin
          hi_q <= rx_byte;
          kind_q <= IRS_K_LO;
        end
        default:
        begin
          kind_q <= IRS_K_PTR;
        end
      endcase
    end
  end

  // word committed only once low byte arrives
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_wr <= '0;
      reg_wr_valid <= 1'b0;
    end
    else
    begin
      reg_wr_valid <= rx_done && !start_ev && !stop_ev && (kind_q == IRS_K_LO);
      if (rx_done && !start_ev && !stop_ev && (kind_q == IRS_K_LO))
      begin
        reg_wr.addr <= ptr_q;
        reg_wr.data <= {hi_q, rx_byte};
      end
    end
  end

  // Read request is a one-cycle pulse; data is taken in the same cycle
  assign reg_rd = '{en: tx_fetch, addr: ptr_q};

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_q <= IRS_WORD_RST;
      tx_sr_q <= IRS_BYTE_RST;
      tx_lo_q <= 1'b0;
    end
    else if (tx_fetch)
    begin
      word_q <= reg_rd_data;
      tx_sr_q <= word_byte(reg_rd_data, 1'b1);
      tx_lo_q <= 1'b0;
    end
    else if (tx_next_lo)
    begin
      tx_sr_q <= word_byte(word_q, 1'b0);
      tx_lo_q <= 1'b1;
    end
    else if (bit_ev && st_q == IRS_ST_TX && !tx_done)
    begin
      tx_sr_q <= {tx_sr_q[6:0], 1'b0};
    end
  end

  // SDA drive is taken low only after SCL has been seen low; any start or stop releases it at once
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drv_low_q <= 1'b0;
    end
    // release on any start or stop
    else if (start_ev || stop_ev)
    begin
      drv_low_q <= 1'b0;
    end
    // change only in the SCL low phase
    else if (scl_fall)
    begin
      // acknowledge in ninth clock; data bits in read
      drv_low_q <= (st_q == IRS_ST_ACK) || ((st_q == IRS_ST_TX) && !tx_sr_q[7]);
    end
  end

  // Open-drain pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !drv_low_q;

  // Status
  assign busy = (st_q != IRS_ST_IDLE);
  assign selected = (st_q == IRS_ST_ACK) || (st_q == IRS_ST_TX) || (st_q == IRS_ST_MACK)
                    || ((st_q == IRS_ST_RX) && (kind_q != IRS_K_ADDR));

endmodule

// *** verification/irs_slave_asserts.sv ***
// Port checks of the two-wire register slave
`timescale 1ns/1ps
module irs_slave_asserts
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial link
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Register side
  input wire irs_pkg::irs_wr_t reg_wr,
  input wire logic reg_wr_valid,
  input wire irs_pkg::irs_rd_t reg_rd,
  input wire logic [irs_pkg::IRS_WORD_W-1:0] reg_rd_data,
  // Status
  input wire logic busy,
  input wire logic selected
);
  import irs_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_oe_hold;
    scl_clk && $past(scl_clk) |-> $stable(sda_oe_n);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved in clock high");
  property p_wr_pulse;
    reg_wr_valid |=> !reg_wr_valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_idle_rel;
    !busy |-> sda_oe_n;
  endproperty
  a_idle_rel: assert property (p_idle_rel) else $error("data driven when idle");
  property p_rd_sel;
    reg_rd.en |-> selected && busy;
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("fetch while unselected");
  property p_wr_sel;
    reg_wr_valid |-> selected;
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write while unselected");
  property p_wr_hold;
    !reg_wr_valid |-> $stable(reg_wr);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word moved");
  property p_ptr_hold;
    !selected |=> $stable(reg_rd.addr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
  property p_wr_ack;
    $rose(reg_wr_valid) |-> ##[1:40] !sda_oe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("low byte not acked");
  c_write: cover property (reg_wr_valid);
  c_read: cover property (reg_rd.en);
  c_ack: cover property ($fell(sda_oe_n));
endmodule
bind irs_slave irs_slave_asserts u_chk
(
  .sys_clk(sys_clk), .nrst(nrst), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_wr(reg_wr), .reg_wr_valid(reg_wr_valid),
  .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .busy(busy), .selected(selected)
);

// *** verification/irs_master_model.sv ***
// Two-wire bus master model
`timescale 1ns/1ps
module irs_master_model
(
  // Serial link
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic bit_x(input logic b, output logic r);
    #31.25 sda_m = b;
    #31.25 scl = 1'b1;
    #31.25 r = sda;
    #31.25 scl = 1'b0;
  endtask
  task automatic start();
    #31.25 sda_m = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b0;
    #62.5 scl = 1'b0;
  endtask
  task automatic stop();
    #31.25 sda_m = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b1;
    #62.5;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic k);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
endmodule

// *** verification/i2c_register_slave_bench.sv ***
// Self-checking bench of the two-wire register slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module i2c_register_slave_bench;
  import irs_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic scl_clk, sda_m, sda_in, sda_out, sda_oe_n, reg_wr_valid, busy, selected, k;
  irs_wr_t reg_wr, last_wr;
  irs_rd_t reg_rd;
  logic [15:0] reg_rd_data = 16'h0000;
  logic [7:0] q;
  int num_errors = 0, check_count = 0, wr_cnt = 0, cycles = 0;
  localparam logic [6:0] ME = IRS_OWN_ADDR_DEF;
  // Open-drain wire with pull-up
  assign sda_in = sda_m & (sda_oe_n ? 1'b1 : sda_out);
  irs_slave #(.OWN_ADDR(ME)) dut (.sys_clk(sys_clk), .nrst(nrst), .scl_clk(scl_clk),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_wr(reg_wr),
    .reg_wr_valid(reg_wr_valid), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .busy(busy), .selected(selected));
  irs_master_model mst (.scl(scl_clk), .sda_m(sda_m), .sda(sda_in));
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    reg_rd_data <= {reg_rd.addr, 8'h5A};
    if (reg_wr_valid)
    begin
      wr_cnt++;
      last_wr = reg_wr;
    end
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic send(input logic [7:0] d, input logic ack, input string n);
    mst.xfer(d, 1'b1, q, k);
    `CHK(n, ack, k)
  endtask
  task automatic t_write();
    mst.start();
    send({ME, IRS_DIR_WRITE}, 1'b0, "addr ack");
    `CHK("selected", 1'b1, selected)
    send(8'h20, 1'b0, "ptr ack");
    send(8'hA5, 1'b0, "hi ack");
    send(8'h3C, 1'b0, "lo ack");
    `CHK("word 1", {8'h20, 16'hA53C}, last_wr)
    send(8'h22, 1'b0, "ptr 2 ack");
    send(8'h01, 1'b0, "hi 2 ack");
    send(8'h80, 1'b0, "lo 2 ack");
    `CHK("word 2", {8'h22, 16'h0180}, last_wr)
    mst.stop();
    repeat (8) @(posedge sys_clk);
    `CHK("busy", 1'b0, busy)
    $display("write done");
  endtask
  task automatic t_abort();
    mst.start();
    send({ME, IRS_DIR_WRITE}, 1'b0, "addr ack");
    send(8'h30, 1'b0, "ptr ack");
    send(8'h77, 1'b0, "hi ack");
    mst.bit_x(1'b0, k);
    mst.bit_x(1'b1, k);
    mst.stop();
    repeat (8) @(posedge sys_clk);
    `CHK("writes", 2, wr_cnt)
    `CHK("pointer", 8'h30, reg_rd.addr)
    $display("abort done");
  endtask
  task automatic t_miss();
    mst.start();
    send({ME ^ 7'h01, IRS_DIR_WRITE}, 1'b1, "miss nack");
    send(8'h00, 1'b1, "ignored");
    `CHK("selected", 1'b0, selected)
    `CHK("idle", 1'b0, busy)
    mst.stop();
    $display("miss done");
  endtask
  task automatic t_read();
    mst.start();
    send({ME, IRS_DIR_WRITE}, 1'b0, "addr ack");
    send(8'h21, 1'b0, "ptr ack");
    mst.start();
    send({ME, IRS_DIR_READ}, 1'b0, "read ack");
    for (int i = 0; i < 2; i++)
    begin
      mst.xfer(8'hFF, 1'b0, q, k);
      `CHK("hi", 8'h21, q)
      mst.xfer(8'hFF, i[0], q, k);
      `CHK("lo", 8'h5A, q)
    end
    `CHK("released", 1'b1, k)
    mst.stop();
    `CHK("writes", 2, wr_cnt)
    $display("read done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_write();
    t_abort();
    t_miss();
    t_read();
    close_out();
  end
endmodule
